/* hdl/cisd_pkg.sv */
// Purpose: shared constants for the capability sub-group decoder
// Assumes: 32-bit instruction word, group code supplied by the top-level decode
// Notes:   field positions are fixed; one constant per field
package cisd_pkg;
  // instruction field positions
  localparam int DIR_BIT   = 22;
  localparam int VAR_BIT   = 21;
  localparam int STAT_LSB  = 16;
  localparam int TGT2_LSB  = 10;
  localparam int MINOR_LSB = 10;
  localparam int SEC_LSB   = 12;
  localparam int RANGE_BIT = 15;
  localparam int FPB_BIT   = 26;
  localparam int AV_LSB    = 10;
  localparam int SG_LSB    = 23;
  localparam logic [4:0] ALL_ONES5 = 5'h1F;
  // routed sub-group codes
  localparam logic [4:0] G_ACQ_CAP_ALT  = 5'h00;
  localparam logic [4:0] G_ACQ_CAP      = 5'h01;
  localparam logic [4:0] G_ACQ_INT_ALT  = 5'h02;
  localparam logic [4:0] G_UOFF_ALT     = 5'h03;
  localparam logic [4:0] G_REG_ALT      = 5'h04;
  localparam logic [4:0] G_UNSC_CAP     = 5'h05;
  localparam logic [4:0] G_POST_IDX     = 5'h06;
  localparam logic [4:0] G_PRE_IDX      = 5'h07;
  localparam logic [4:0] G_TRANSL       = 5'h08;
  localparam logic [4:0] G_CAS          = 5'h09;
  localparam logic [4:0] G_REG_CAP      = 5'h0A;
  localparam logic [4:0] G_MISC0        = 5'h0B;
  localparam logic [4:0] G_BR_SEAL_DIR  = 5'h0C;
  localparam logic [4:0] G_PAIR_BRANCH  = 5'h0D;
  localparam logic [4:0] G_CVT_IMPL     = 5'h0E;
  localparam logic [4:0] G_ONE_SRC      = 5'h0F;
  localparam logic [4:0] G_BR_SEAL_IND  = 5'h10;
  localparam logic [4:0] G_MISC1        = 5'h11;
  localparam logic [4:0] G_BR_TO_SEAL   = 5'h12;
  localparam logic [4:0] G_MISC2        = 5'h13;
  localparam logic [4:0] G_IMM_BOUNDS   = 5'h14;
  localparam logic [4:0] G_LOGIC_IMM    = 5'h15;
  localparam logic [4:0] G_UNSC_ALT     = 5'h16;
  // access size codes
  localparam logic [2:0] SZ_BYTE  = 3'h0;
  localparam logic [2:0] SZ_HALF  = 3'h1;
  localparam logic [2:0] SZ_WORD  = 3'h2;
  localparam logic [2:0] SZ_DWORD = 3'h3;
  localparam logic [2:0] SZ_CAP   = 3'h4;
  localparam logic [2:0] SZ_NONE  = 3'h7;
  // operation identifiers
  localparam logic [5:0] OP_NONE          = 6'h00;
  localparam logic [5:0] OP_STORE_REL     = 6'h01;
  localparam logic [5:0] OP_LOAD_ACQ      = 6'h02;
  localparam logic [5:0] OP_BYTE_STORE_REL= 6'h03;
  localparam logic [5:0] OP_BYTE_LOAD_ACQ = 6'h04;
  localparam logic [5:0] OP_REG_STORE     = 6'h05;
  localparam logic [5:0] OP_REG_LOAD      = 6'h06;
  localparam logic [5:0] OP_BYTE_STORE    = 6'h07;
  localparam logic [5:0] OP_BYTE_LOAD     = 6'h08;
  localparam logic [5:0] OP_SBYTE_LOAD_X  = 6'h09;
  localparam logic [5:0] OP_SBYTE_LOAD_W  = 6'h0A;
  localparam logic [5:0] OP_SHALF_LOAD_X  = 6'h0B;
  localparam logic [5:0] OP_SHALF_LOAD_W  = 6'h0C;
  localparam logic [5:0] OP_HALF_STORE    = 6'h0D;
  localparam logic [5:0] OP_HALF_LOAD     = 6'h0E;
  localparam logic [5:0] OP_FP_STORE      = 6'h0F;
  localparam logic [5:0] OP_FP_LOAD       = 6'h10;
  localparam logic [5:0] OP_UNSC_STORE    = 6'h11;
  localparam logic [5:0] OP_UNSC_LOAD     = 6'h12;
  localparam logic [5:0] OP_POST_STORE    = 6'h13;
  localparam logic [5:0] OP_POST_LOAD     = 6'h14;
  localparam logic [5:0] OP_PRE_STORE     = 6'h15;
  localparam logic [5:0] OP_PRE_LOAD      = 6'h16;
  localparam logic [5:0] OP_UNPRIV_STORE  = 6'h17;
  localparam logic [5:0] OP_UNPRIV_LOAD   = 6'h18;
  localparam logic [5:0] OP_CSWAP         = 6'h19;
  localparam logic [5:0] OP_CSWAP_REL     = 6'h1A;
  localparam logic [5:0] OP_CSWAP_ACQ     = 6'h1B;
  localparam logic [5:0] OP_CSWAP_ACQ_REL = 6'h1C;
  localparam logic [5:0] OP_TAG_CLEAR     = 6'h1D;
  localparam logic [5:0] OP_CAP_COPY      = 6'h1E;
  localparam logic [5:0] OP_SEALED_BR     = 6'h1F;
  localparam logic [5:0] OP_SEALED_BR_LINK= 6'h20;
  localparam logic [5:0] OP_SEALED_RET    = 6'h21;
  localparam logic [5:0] OP_PAIR_LD_BR    = 6'h22;
  localparam logic [5:0] OP_PAIR_LD_BR_LNK= 6'h23;
  localparam logic [5:0] OP_CVT_D         = 6'h24;
  localparam logic [5:0] OP_CVT_P         = 6'h25;
  localparam logic [5:0] OP_CVT_D_ZERO    = 6'h26;
  localparam logic [5:0] OP_CVT_P_ZERO    = 6'h27;
  localparam logic [5:0] OP_REPR_LENGTH   = 6'h28;
  localparam logic [5:0] OP_REPR_MASK     = 6'h29;
  localparam logic [5:0] OP_MEM_IND_BR    = 6'h2A;
  localparam logic [5:0] OP_MEM_IND_BR_LNK= 6'h2B;
  localparam logic [5:0] OP_BUILD         = 6'h2C;
  localparam logic [5:0] OP_TYPE_COPY     = 6'h2D;
  localparam logic [5:0] OP_COND_SEAL     = 6'h2E;
  localparam logic [5:0] OP_VALUE_COPY    = 6'h2F;
  localparam logic [5:0] OP_SEAL_CAP      = 6'h30;
  localparam logic [5:0] OP_UNSEAL        = 6'h31;
  localparam logic [5:0] OP_SUBSET_CHECK  = 6'h32;
  localparam logic [5:0] OP_BOUNDS_UNSC   = 6'h33;
  localparam logic [5:0] OP_BOUNDS_SCALED = 6'h34;
  localparam logic [5:0] OP_FLAGS_CLEAR   = 6'h35;
  localparam logic [5:0] OP_FLAGS_OR      = 6'h36;
  localparam logic [5:0] OP_FLAGS_XOR     = 6'h37;
  // register map and reset values
  localparam logic [11:0] ADDR_CTRL  = 12'h000;
  localparam logic [11:0] ADDR_COUNT = 12'h004;
  localparam logic [11:0] ADDR_LAST  = 12'h008;
  localparam logic        CTRL_EN_RST = 1'b1;
  localparam logic [15:0] COUNT_RST   = 16'h0000;
endpackage

/* hdl/cisd_pipe_reg.sv */
// Purpose: output register stage of the decoder
// Assumes: same clock and synchronous reset as the decoder
// Notes:   one cycle of latency, every output from a flip-flop
`timescale 1ns/1ps
`default_nettype none
module cisd_pipe_reg
  import cisd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       valid_d,
  input  wire logic       unalloc_d,
  input  wire logic [5:0] op_d,
  input  wire logic [2:0] size_d,
  input  wire logic       load_d,
  input  wire logic       alt_d,
  output logic            valid_q,
  output logic            unalloc_q,
  output logic [5:0]      op_q,
  output logic [2:0]      size_q,
  output logic            load_q,
  output logic            alt_q
);
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      valid_q   <= 1'b0;
      unalloc_q <= 1'b0;
      op_q      <= OP_NONE;
      size_q    <= SZ_NONE;
      load_q    <= 1'b0;
      alt_q     <= 1'b0;
    end
    else
    begin
      valid_q   <= valid_d;
      unalloc_q <= unalloc_d;
      op_q      <= op_d;
      size_q    <= size_d;
      load_q    <= load_d;
      alt_q     <= alt_d;
    end
  end
endmodule
`default_nettype wire

/* hdl/cisd_apb_regs.sv */
// Purpose: APB slave holding decoder control and status
// Assumes: APB3 master on the same clock
// Notes:   two-cycle access phase, unmapped address answers with pslverr
`timescale 1ns/1ps
`default_nettype none
module cisd_apb_regs
  import cisd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        unalloc_evt,
  input  wire logic [5:0]  last_op,
  output logic             dec_en
);
  logic        acc;
  logic        hit;
  logic [15:0] count_q;
  logic [31:0] rd;
  assign acc = psel & penable & pready;
  assign hit = (paddr == ADDR_CTRL) | (paddr == ADDR_COUNT) | (paddr == ADDR_LAST);
  always_comb
  begin
    rd = 32'h0000_0000;
    if (paddr == ADDR_CTRL)
      rd = {31'h0000_0000, dec_en};
    else if (paddr == ADDR_COUNT)
      rd = {16'h0000, count_q};
    else if (paddr == ADDR_LAST)
      rd = {26'h000_0000, last_op};
  end
  // ready is registered, so it drops the cycle after each completion
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? rd : 32'h0000_0000;
    end
  end
  always_ff @(posedge clk)
  begin
    if (srst)
      dec_en <= CTRL_EN_RST;
    else if (acc & pwrite & (paddr == ADDR_CTRL))
      dec_en <= pwdata[0];
  end
  // a new event beats a software clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (srst)
      count_q <= COUNT_RST;
    else if (acc & pwrite & (paddr == ADDR_COUNT))
      count_q <= unalloc_evt ? 16'h0001 : COUNT_RST;
    else if (unalloc_evt & (count_q != 16'hFFFF))
      count_q <= count_q + 16'h0001;
  end
endmodule
`default_nettype wire

/* hdl/cisd_decoder.sv */
// Purpose: decode of the capability-extension instruction sub-groups
// Assumes: INSTR_GROUP comes from the top-level decode on the same clock
// Notes:   result appears one REF_CLK edge after the word is presented
`timescale 1ns/1ps
`default_nettype none
module cisd_decoder
  import cisd_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        SRST,
  input  wire logic        INSTR_VALID,
  input  wire logic [31:0] INSTR_WORD,
  input  wire logic [4:0]  INSTR_GROUP,
  output logic             OP_VALID,
  output logic             OP_UNALLOC,
  output logic [5:0]       OP_ID,
  output logic [2:0]       OP_SIZE,
  output logic             OP_IS_LOAD,
  output logic             OP_ALT_BASE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR
);
  logic       dir;
  logic       vbit;
  logic [4:0] stat_fld;
  logic [4:0] tgt2_fld;
  logic [1:0] mn;
  logic       sec0;
  logic       rng;
  logic       fpb;
  logic [1:0] av;
  logic [1:0] sg;
  logic       dec_en;
  logic       hit;
  logic [5:0] op_d;
  logic [2:0] size_d;
  logic       load_d;
  logic       alt_d;
  logic       valid_d;
  logic       unalloc_d;
  logic       ones;

  assign dir  = INSTR_WORD[DIR_BIT];
  assign vbit = INSTR_WORD[VAR_BIT];
  assign stat_fld = INSTR_WORD[STAT_LSB +: 5];
  assign tgt2_fld = INSTR_WORD[TGT2_LSB +: 5];
  assign mn   = INSTR_WORD[MINOR_LSB +: 2];
  assign sec0 = INSTR_WORD[SEC_LSB];
  assign rng  = INSTR_WORD[RANGE_BIT];
  assign fpb  = INSTR_WORD[FPB_BIT];
  assign av   = INSTR_WORD[AV_LSB +: 2];
  assign sg   = INSTR_WORD[SG_LSB +: 2];
  assign ones = (stat_fld == ALL_ONES5) && (tgt2_fld == ALL_ONES5);

  always_comb
  begin
    hit    = 1'b0;
    op_d   = OP_NONE;
    size_d = SZ_NONE;
    load_d = 1'b0;
    alt_d  = 1'b0;
    case (INSTR_GROUP)
      G_ACQ_CAP_ALT, G_ACQ_CAP:
      begin
        hit    = ones;
        op_d   = dir ? OP_LOAD_ACQ : OP_STORE_REL;
        size_d = SZ_CAP;
        load_d = dir;
        alt_d  = (INSTR_GROUP == G_ACQ_CAP_ALT);
      end
      G_ACQ_INT_ALT:
      begin
        hit    = ones;
        alt_d  = 1'b1;
        load_d = dir;
        size_d = vbit ? SZ_DWORD : SZ_BYTE;
        if (vbit)
          op_d = dir ? OP_LOAD_ACQ : OP_STORE_REL;
        else
          op_d = dir ? OP_BYTE_LOAD_ACQ : OP_BYTE_STORE_REL;
      end
      G_UOFF_ALT:
      begin
        hit    = 1'b1;
        alt_d  = 1'b1;
        load_d = dir;
        op_d   = dir ? OP_REG_LOAD : OP_REG_STORE;
        case (mn)
          2'h0:    size_d = SZ_CAP;
          2'h1:    size_d = SZ_BYTE;
          2'h2:    size_d = SZ_WORD;
          default: size_d = SZ_DWORD;
        endcase
      end
      G_REG_ALT:
      begin
        hit    = 1'b1;
        alt_d  = 1'b1;
        load_d = dir | (~vbit & (mn == 2'h1 || mn == 2'h2));
        case ({dir, vbit, mn})
          4'h0:    begin op_d = OP_BYTE_STORE;   size_d = SZ_BYTE;  end
          4'h1:    begin op_d = OP_SBYTE_LOAD_X; size_d = SZ_BYTE;  end
          4'h2:    begin op_d = OP_SHALF_LOAD_X; size_d = SZ_HALF;  end
          4'h3:    begin op_d = OP_HALF_STORE;   size_d = SZ_HALF;  end
          4'h4:    begin op_d = OP_REG_STORE;    size_d = SZ_WORD;  end
          4'h5:    begin op_d = OP_REG_STORE;    size_d = SZ_DWORD; end
          4'h6:    begin op_d = OP_FP_STORE;     size_d = SZ_DWORD; end
          4'h7:    begin op_d = OP_FP_STORE;     size_d = SZ_WORD;  end
          4'h8:    begin op_d = OP_BYTE_LOAD;    size_d = SZ_BYTE;  end
          4'h9:    begin op_d = OP_SBYTE_LOAD_W; size_d = SZ_BYTE;  end
          4'hA:    begin op_d = OP_SHALF_LOAD_W; size_d = SZ_HALF;  end
          4'hB:    begin op_d = OP_HALF_LOAD;    size_d = SZ_HALF;  end
          4'hC:    begin op_d = OP_REG_LOAD;     size_d = SZ_WORD;  end
          4'hD:    begin op_d = OP_REG_LOAD;     size_d = SZ_DWORD; end
          4'hE:    begin op_d = OP_FP_LOAD;      size_d = SZ_DWORD; end
          default: begin op_d = OP_FP_LOAD;      size_d = SZ_WORD;  end
        endcase
      end
      G_UNSC_CAP, G_POST_IDX, G_PRE_IDX, G_TRANSL, G_REG_CAP:
      begin
        hit    = ~mn[1];
        size_d = SZ_CAP;
        load_d = mn[0];
        case (INSTR_GROUP)
          G_UNSC_CAP: op_d = mn[0] ? OP_UNSC_LOAD : OP_UNSC_STORE;
          G_POST_IDX: op_d = mn[0] ? OP_POST_LOAD : OP_POST_STORE;
          G_PRE_IDX:  op_d = mn[0] ? OP_PRE_LOAD : OP_PRE_STORE;
          G_TRANSL:   op_d = mn[0] ? OP_UNPRIV_LOAD : OP_UNPRIV_STORE;
          default:    op_d = mn[0] ? OP_REG_LOAD : OP_REG_STORE;
        endcase
      end
      G_CAS:
      begin
        hit    = mn[1];
        size_d = SZ_CAP;
        load_d = 1'b1;
        case ({mn[0], sec0})
          2'h0:    op_d = OP_CSWAP;
          2'h1:    op_d = OP_CSWAP_REL;
          2'h2:    op_d = OP_CSWAP_ACQ;
          default: op_d = OP_CSWAP_ACQ_REL;
        endcase
      end
      G_MISC0:
      begin
        hit  = ~mn[0];
        op_d = mn[1] ? OP_CAP_COPY : OP_TAG_CLEAR;
      end
      G_BR_SEAL_DIR, G_BR_TO_SEAL:
      begin
        hit = (mn != 2'h3);
        case (mn)
          2'h0:    op_d = OP_SEALED_BR;
          2'h1:    op_d = OP_SEALED_BR_LINK;
          default: op_d = OP_SEALED_RET;
        endcase
      end
      G_PAIR_BRANCH:
      begin
        hit    = ~mn[1];
        size_d = SZ_CAP;
        load_d = 1'b1;
        op_d   = mn[0] ? OP_PAIR_LD_BR_LNK : OP_PAIR_LD_BR;
      end
      G_CVT_IMPL:
      begin
        hit = 1'b1;
        case (mn)
          2'h0:    op_d = OP_CVT_D;
          2'h1:    op_d = OP_CVT_P;
          2'h2:    op_d = OP_CVT_D_ZERO;
          default: op_d = OP_CVT_P_ZERO;
        endcase
      end
      G_ONE_SRC:
      begin
        hit  = ~mn[1];
        op_d = mn[0] ? OP_REPR_MASK : OP_REPR_LENGTH;
      end
      G_BR_SEAL_IND:
      begin
        hit    = 1'b1;
        size_d = SZ_CAP;
        load_d = 1'b1;
        op_d   = vbit ? OP_MEM_IND_BR_LNK : OP_MEM_IND_BR;
      end
      G_MISC1:
      begin
        hit = 1'b1;
        case (mn)
          2'h0:    op_d = OP_BUILD;
          2'h1:    op_d = OP_TYPE_COPY;
          2'h2:    op_d = OP_COND_SEAL;
          default: op_d = OP_VALUE_COPY;
        endcase
      end
      G_MISC2:
      begin
        hit = (mn != 2'h3);
        case (mn)
          2'h0:    op_d = OP_SEAL_CAP;
          2'h1:    op_d = OP_UNSEAL;
          default: op_d = OP_SUBSET_CHECK;
        endcase
      end
      G_IMM_BOUNDS:
      begin
        hit  = 1'b1;
        op_d = rng ? OP_BOUNDS_SCALED : OP_BOUNDS_UNSC;
      end
      G_LOGIC_IMM:
      begin
        hit = (mn != 2'h3);
        case (mn)
          2'h0:    op_d = OP_FLAGS_CLEAR;
          2'h1:    op_d = OP_FLAGS_OR;
          default: op_d = OP_FLAGS_XOR;
        endcase
      end
      G_UNSC_ALT:
      begin
        hit    = ~fpb && (av == 2'h3) && sg[1];
        alt_d  = 1'b1;
        size_d = SZ_CAP;
        load_d = sg[0];
        op_d   = sg[0] ? OP_UNSC_LOAD : OP_UNSC_STORE;
      end
      default:
      begin
        hit = 1'b0;
      end
    endcase
  end

  // disabling the extension turns every routed word into an unallocated one
  assign valid_d   = INSTR_VALID & dec_en & hit;
  assign unalloc_d = INSTR_VALID & ~(dec_en & hit);

  // fields are forced to OP_NONE and SZ_NONE on a miss so a trap never carries a half-decoded op
  cisd_pipe_reg u_pipe
  (
    .clk       (REF_CLK),
    .srst      (SRST),
    .valid_d   (valid_d),
    .unalloc_d (unalloc_d),
    .op_d      (valid_d ? op_d : OP_NONE),
    .size_d    (valid_d ? size_d : SZ_NONE),
    .load_d    (valid_d & load_d),
    .alt_d     (valid_d & alt_d),
    .valid_q   (OP_VALID),
    .unalloc_q (OP_UNALLOC),
    .op_q      (OP_ID),
    .size_q    (OP_SIZE),
    .load_q    (OP_IS_LOAD),
    .alt_q     (OP_ALT_BASE)
  );

  cisd_apb_regs u_regs
  (
    .clk         (REF_CLK),
    .srst        (SRST),
    .psel        (PSEL),
    .penable     (PENABLE),
    .pwrite      (PWRITE),
    .paddr       (PADDR),
    .pwdata      (PWDATA),
    .prdata      (PRDATA),
    .pready      (PREADY),
    .pslverr     (PSLVERR),
    .unalloc_evt (OP_UNALLOC),
    .last_op     (OP_ID),
    .dec_en      (dec_en)
  );

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SRST);

  a_acq_alt_dir: assert property (
    INSTR_VALID && dec_en && INSTR_GROUP == G_ACQ_CAP_ALT && ones
    |=> OP_VALID && OP_ALT_BASE && OP_IS_LOAD == $past(dir)
        && OP_ID == ($past(dir) ? OP_LOAD_ACQ : OP_STORE_REL))
    else $error("alt base cap acquire/release decoded wrongly");

  a_acq_norm_fields: assert property (
    INSTR_VALID && INSTR_GROUP == G_ACQ_CAP && (stat_fld != ALL_ONES5)
    |=> OP_UNALLOC && !OP_VALID)
    else $error("normal base acquire/release accepted bad fields");

  a_acq_int_byte: assert property (
    INSTR_VALID && dec_en && INSTR_GROUP == G_ACQ_INT_ALT && ones && !vbit
    |=> OP_SIZE == SZ_BYTE && OP_ID == ($past(dir) ? OP_BYTE_LOAD_ACQ : OP_BYTE_STORE_REL))
    else $error("integer acquire/release byte form wrong");

  a_uoff_size_map: assert property (
    INSTR_VALID && dec_en && INSTR_GROUP == G_UOFF_ALT && mn == 2'h1
    |=> OP_SIZE == SZ_BYTE && OP_ALT_BASE && OP_IS_LOAD == $past(dir))
    else $error("unsigned offset size map wrong");

  a_cas_acq_rel: assert property (
    INSTR_VALID && dec_en && INSTR_GROUP == G_CAS && mn == 2'h3 && sec0
    |=> OP_VALID && OP_ID == OP_CSWAP_ACQ_REL)
    else $error("compare-swap ordering wrong");

  a_bounds_form: assert property (
    INSTR_VALID && dec_en && INSTR_GROUP == G_IMM_BOUNDS
    |=> OP_ID == ($past(rng) ? OP_BOUNDS_SCALED : OP_BOUNDS_UNSC))
    else $error("bounds form wrong");

  a_flags_eleven: assert property (
    INSTR_VALID && INSTR_GROUP == G_LOGIC_IMM && mn == 2'h3
    |=> OP_UNALLOC && !OP_VALID)
    else $error("flags group accepted selector 11");

  a_one_result: assert property (
    $past(INSTR_VALID) == (OP_VALID ^ OP_UNALLOC) && !(OP_VALID && OP_UNALLOC))
    else $error("not exactly one result per word");

endmodule
`default_nettype wire

/* test/cisd_fetch_model.sv */
// Purpose: fetch-side model presenting one word per request
// Assumes: requests change just after a rising edge
// Notes:   idle lines show the inverse of the last word
`timescale 1ns/1ps
`default_nettype none
module cisd_fetch_model
  import cisd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        req,
  input  wire logic [31:0] req_word,
  input  wire logic [4:0]  req_group,
  output logic             valid,
  output logic [31:0]      word,
  output logic [4:0]       group
);
  logic [31:0] last_q = 32'h0;
  logic [4:0]  lastg_q = 5'h00;
  always_ff @(posedge clk)
  begin
    if (req)
    begin
      last_q <= req_word;
      lastg_q <= req_group;
    end
  end
  // stale fields flip so a decode that ignores valid is caught
  assign valid = req;
  assign word  = req ? req_word : ~last_q;
  assign group = req ? req_group : ~lastg_q;
endmodule
`default_nettype wire

/* test/cisd_decoder_bench.sv */
// Purpose: self-checking bench for the sub-group decoder
// Assumes: one cycle decode latency, APB answer awaited
// Notes:   unassigned selector values expect the unallocated flag
`timescale 1ns/1ps
`default_nettype none
module cisd_decoder_bench
  import cisd_pkg::*;
;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        req = 1'b0;
  logic [31:0] rw = 32'h0;
  logic [4:0]  rg = 5'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        iv, ov, ou, ld, al, pr, pe;
  logic [31:0] iw, prd;
  logic [4:0]  ig;
  logic [5:0]  oid;
  logic [2:0]  osz;
  int          errors = 0;
  int          n_compared = 0;
  always #10 clk = ~clk;
  cisd_fetch_model u_fetch (.clk(clk), .req(req), .req_word(rw), .req_group(rg),
    .valid(iv), .word(iw), .group(ig));
  cisd_decoder u_dut (.REF_CLK(clk), .SRST(srst), .INSTR_VALID(iv), .INSTR_WORD(iw),
    .INSTR_GROUP(ig), .OP_VALID(ov), .OP_UNALLOC(ou), .OP_ID(oid), .OP_SIZE(osz),
    .OP_IS_LOAD(ld), .OP_ALT_BASE(al), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prd), .PREADY(pr),
    .PSLVERR(pe));
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask
  function logic [31:0] wf(input logic dr, input logic vr, input logic [20:0] lo);
    return {9'h0, dr, vr, lo};
  endfunction
  task d(input logic [4:0] g, input logic [31:0] w, input logic [5:0] op);
    @(posedge clk);
    req <= 1'b1;
    rg <= g;
    rw <= w;
    @(posedge clk);
    req <= 1'b0;
    #1;
    chk("valid", {31'h0, ov}, {31'h0, op != OP_NONE});
    chk("unalloc", {31'h0, ou}, {31'h0, op == OP_NONE});
    chk("op", {26'h0, oid}, {26'h0, op});
  endtask
  task ds(input logic [2:0] sz, input logic l, input logic a);
    chk("size", {29'h0, osz}, {29'h0, sz});
    chk("load", {31'h0, ld}, {31'h0, l});
    chk("alt", {31'h0, al}, {31'h0, a});
  endtask
  // ops packed with minor 0 in the low six bits
  task tbl(input logic [4:0] g, input logic [23:0] ops);
    for (int m = 0; m < 4; m++)
      d(g, {20'h0, m[1:0], 10'h0}, ops[m*6+:6]);
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
           output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed: the wait ends on pready, the watchdog bounds it
    do
      @(posedge clk);
    while (pr !== 1'b1);
    rd = prd;
    er = pe;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task t_acq;
    logic [5:0] t3 [4] = '{OP_BYTE_STORE_REL, OP_STORE_REL, OP_BYTE_LOAD_ACQ, OP_LOAD_ACQ};
    for (int i = 0; i < 2; i++)
    begin
      d(G_ACQ_CAP_ALT, wf(i[0], 0, 21'h1F7C00), i ? OP_LOAD_ACQ : OP_STORE_REL);
      ds(SZ_CAP, i[0], 1'b1);
      d(G_ACQ_CAP, wf(i[0], 0, 21'h1F7C00), i ? OP_LOAD_ACQ : OP_STORE_REL);
      ds(SZ_CAP, i[0], 1'b0);
    end
    for (int i = 0; i < 4; i++)
      d(G_ACQ_INT_ALT, wf(i[1], i[0], 21'h1F7C00), t3[i]);
    d(G_ACQ_CAP, wf(0, 0, 21'h0F7C00), OP_NONE);
    d(G_ACQ_CAP_ALT, wf(1, 0, 21'h1F3C00), OP_NONE);
    $display("t_acq done");
  endtask
  task t_ls;
    // load direction per row: signed loads sit among the store rows
    logic [15:0] lm = 16'hFF06;
    logic [2:0] s4 [4] = '{SZ_CAP, SZ_BYTE, SZ_WORD, SZ_DWORD};
    logic [2:0] s8 [8] = '{SZ_BYTE, SZ_BYTE, SZ_HALF, SZ_HALF,
                           SZ_WORD, SZ_DWORD, SZ_DWORD, SZ_WORD};
    logic [5:0] t [16] = '{OP_BYTE_STORE, OP_SBYTE_LOAD_X, OP_SHALF_LOAD_X, OP_HALF_STORE,
      OP_REG_STORE, OP_REG_STORE, OP_FP_STORE, OP_FP_STORE, OP_BYTE_LOAD, OP_SBYTE_LOAD_W,
      OP_SHALF_LOAD_W, OP_HALF_LOAD, OP_REG_LOAD, OP_REG_LOAD, OP_FP_LOAD, OP_FP_LOAD};
    for (int i = 0; i < 8; i++)
    begin
      d(G_UOFF_ALT, wf(i[2], 0, {i[1:0], 10'h0}), i[2] ? OP_REG_LOAD : OP_REG_STORE);
      ds(s4[i[1:0]], i[2], 1'b1);
    end
    for (int i = 0; i < 16; i++)
    begin
      d(G_REG_ALT, wf(i[3], i[2], {i[1:0], 10'h0}), t[i]);
      ds(s8[i[2:0]], lm[i], 1'b1);
    end
    $display("t_ls done");
  endtask
  task t_imm;
    tbl(G_UNSC_CAP, {OP_NONE, OP_NONE, OP_UNSC_LOAD, OP_UNSC_STORE});
    tbl(G_POST_IDX, {OP_NONE, OP_NONE, OP_POST_LOAD, OP_POST_STORE});
    tbl(G_PRE_IDX, {OP_NONE, OP_NONE, OP_PRE_LOAD, OP_PRE_STORE});
    tbl(G_TRANSL, {OP_NONE, OP_NONE, OP_UNPRIV_LOAD, OP_UNPRIV_STORE});
    tbl(G_REG_CAP, {OP_NONE, OP_NONE, OP_REG_LOAD, OP_REG_STORE});
    ds(SZ_NONE, 1'b0, 1'b0);
    d(G_UNSC_ALT, 32'h01000C00, OP_UNSC_STORE);
    ds(SZ_CAP, 1'b0, 1'b1);
    d(G_UNSC_ALT, 32'h01800C00, OP_UNSC_LOAD);
    d(G_UNSC_ALT, 32'h05000C00, OP_NONE);
    d(G_UNSC_ALT, 32'h01000800, OP_NONE);
    for (int i = 0; i < 4; i++)
      d(G_CAS, {19'h0, i[0], 1'b1, i[1], 10'h0}, OP_CSWAP + 6'(i));
    $display("t_imm done");
  endtask
  task t_misc;
    tbl(G_MISC0, {OP_NONE, OP_CAP_COPY, OP_NONE, OP_TAG_CLEAR});
    tbl(G_BR_SEAL_DIR, {OP_NONE, OP_SEALED_RET, OP_SEALED_BR_LINK, OP_SEALED_BR});
    tbl(G_PAIR_BRANCH, {OP_NONE, OP_NONE, OP_PAIR_LD_BR_LNK, OP_PAIR_LD_BR});
    tbl(G_CVT_IMPL, {OP_CVT_P_ZERO, OP_CVT_D_ZERO, OP_CVT_P, OP_CVT_D});
    tbl(G_ONE_SRC, {OP_NONE, OP_NONE, OP_REPR_MASK, OP_REPR_LENGTH});
    d(G_BR_SEAL_IND, wf(0, 0, 0), OP_MEM_IND_BR);
    d(G_BR_SEAL_IND, wf(0, 1, 0), OP_MEM_IND_BR_LNK);
    tbl(G_MISC1, {OP_VALUE_COPY, OP_COND_SEAL, OP_TYPE_COPY, OP_BUILD});
    tbl(G_BR_TO_SEAL, {OP_NONE, OP_SEALED_RET, OP_SEALED_BR_LINK, OP_SEALED_BR});
    tbl(G_MISC2, {OP_NONE, OP_SUBSET_CHECK, OP_UNSEAL, OP_SEAL_CAP});
    d(G_IMM_BOUNDS, 32'h0, OP_BOUNDS_UNSC);
    d(G_IMM_BOUNDS, 32'h8000, OP_BOUNDS_SCALED);
    tbl(G_LOGIC_IMM, {OP_NONE, OP_FLAGS_XOR, OP_FLAGS_OR, OP_FLAGS_CLEAR});
    $display("t_misc done");
  endtask
  task t_apb;
    logic [31:0] rd;
    logic        er;
    apb(1'b0, ADDR_CTRL, 32'h0, rd, er);
    chk("ctrl reset", rd, {31'h0, CTRL_EN_RST});
    apb(1'b1, ADDR_COUNT, 32'h0, rd, er);
    apb(1'b1, ADDR_CTRL, 32'h0, rd, er);
    // a disabled decoder must refuse even a well-formed word
    d(G_MISC0, 32'h0, OP_NONE);
    apb(1'b1, ADDR_CTRL, 32'h1, rd, er);
    d(G_MISC0, 32'h0, OP_TAG_CLEAR);
    d(G_MISC0, 32'h400, OP_NONE);
    apb(1'b0, ADDR_COUNT, 32'h0, rd, er);
    chk("count", rd, 32'h2);
    chk("count err", {31'h0, er}, 32'h0);
    apb(1'b1, 12'h00C, 32'h0, rd, er);
    chk("unmapped err", {31'h0, er}, 32'h1);
    apb(1'b0, 12'h00C, 32'h0, rd, er);
    chk("unmapped data", rd, 32'h0);
    $display("t_apb done");
  endtask
  task finish_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    t_acq;
    t_ls;
    t_imm;
    t_misc;
    t_apb;
    finish_test;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test;
  end
endmodule
`default_nettype wire
